// ==== sspc_core.sv ====
// Synchronous serial port core: divider, FIFOs, frame engine, status
`timescale 1ns/100ps
`include "sspc_cfg.svh"
module sspc_core #(
   parameter int DEPTH = 8,
   parameter int RX_TIMEOUT_CYCLES = 4096
) (
   // Clock and reset
   input wire logic CLOCK_I,
   input wire logic RST_I,
   // Configuration
   input wire logic ENABLE_I,
   input wire logic SLAVE_I,
   input wire sspc_pkg::sspc_fmt_e FORMAT_I,
   input wire logic [3:0] SIZE_I,
   input wire logic POLARITY_I,
   input wire logic PHASE_I,
   input wire logic [7:0] PRESCALE_I,
   input wire logic [7:0] RATE_I,
   input wire logic [3:0] IRQ_MASK_I,
   input wire logic OVERRUN_CLEAR_I,
   // Data path
   input wire logic [15:0] TX_DATA_I,
   input wire logic TX_WRITE_I,
   output logic TX_READY_O,
   input wire logic RX_READ_I,
   output logic [15:0] RX_DATA_O,
   output logic RX_VALID_O,
   // Status
   output logic [3:0] RAW_IRQ_O,
   output logic [3:0] MASKED_IRQ_O,
   output logic IRQ_O,
   output logic BUSY_O,
   // Serial pins
   input wire logic SCLK_I,
   output logic SCLK_O,
   output logic SCLK_OE_O,
   input wire logic FSEL_I,
   output logic FSEL_O,
   output logic FSEL_OE_O,
   input wire logic SDI_I,
   output logic SDO_O,
   output logic SDO_OE_O
);
   import sspc_pkg::*;

   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;
   localparam logic [CW-1:0] FULL = CW'(DEPTH);
   localparam logic [CW-1:0] HALF = CW'(DEPTH / 2);

   // Pointer wrap relies on a power of two depth
   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || RX_TIMEOUT_CYCLES < 2 ||
          RX_TIMEOUT_CYCLES > 65535)
      begin : g_bad
         $error("sspc_core: unsupported DEPTH or RX_TIMEOUT_CYCLES");
      end
   endgenerate

   sspc_state_e state;
   logic [4:0] bi;
   logic half;
   logic sclk, fsel, sdo;
   logic [15:0] txw, rxsh;
   logic push_d;
   logic [15:0] tx_mem [DEPTH];
   logic [15:0] rx_mem [DEPTH];
   logic [AW-1:0] tx_wr, tx_rd, rx_wr, rx_rd;
   logic [CW-1:0] tx_cnt, rx_cnt;
   logic [6:0] pre_cnt;
   logic [7:0] rate_cnt;
   logic [2:0] sclk_s, fsel_s;
   logic [1:0] sdi_s;
   logic [`SSPC_TO_W-1:0] to_cnt;
   logic rx_timeout, ovr;

   // Effective settings per format
   logic pulse, cmd, eff_pol, eff_phase, tick;
   logic [3:0] sz;
   logic [4:0] last, rx_first;
   logic [15:0] tx_head;
   assign pulse = (FORMAT_I == SSPC_FMT_PULSE);
   assign cmd = (FORMAT_I == SSPC_FMT_CMD);
   assign sz = (SIZE_I < `SSPC_MIN_SIZE) ? `SSPC_MIN_SIZE : SIZE_I;
   assign eff_pol = (FORMAT_I == SSPC_FMT_SPI) ? POLARITY_I : 1'b0;
   assign eff_phase = pulse ? 1'b1 : (cmd ? 1'b0 : PHASE_I);
   assign last = pulse ? {1'b0, sz} + `SSPC_PULSE_LEAD :
                 cmd ? {1'b0, sz} + `SSPC_CMD_BITS + `SSPC_CMD_GAP : {1'b0, sz};
   assign rx_first = pulse ? `SSPC_PULSE_LEAD :
                     cmd ? `SSPC_CMD_BITS + `SSPC_CMD_GAP : `SSPC_BIT_ZERO;
   // head slot is stale data when empty
   assign tx_head = tx_mem[tx_rd];

   // Outgoing bit for a frame position, MSB first
   function automatic logic tx_bit(input sspc_fmt_e f, input logic [3:0] s,
                                   input logic [15:0] w, input logic [4:0] b);
      logic [4:0] idx;
      idx = 5'h00;
      tx_bit = 1'b0;
      case (f)
         SSPC_FMT_SPI:
         begin
            idx = {1'b0, s} - b;
            tx_bit = (b <= {1'b0, s}) & w[idx[3:0]];
         end
         SSPC_FMT_PULSE:
         begin
            idx = {1'b0, s} + `SSPC_PULSE_LEAD - b;
            tx_bit = (b != `SSPC_BIT_ZERO) & (b <= {1'b0, s} + `SSPC_PULSE_LEAD) &
                     w[idx[3:0]];
         end
         SSPC_FMT_CMD:
         begin
            idx = `SSPC_CMD_BITS - 5'h01 - b;
            tx_bit = (b < `SSPC_CMD_BITS) & w[idx[3:0]];
         end
         default: tx_bit = 1'b0;
      endcase
   endfunction

   // Pin synchronisers; stage 0 feeds only stage 1
   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
      begin
         sclk_s <= 3'h0;
         fsel_s <= 3'h7;
         sdi_s <= 2'h0;
      end
      else
      begin
         sclk_s <= {sclk_s[1:0], SCLK_I};
         fsel_s <= {fsel_s[1:0], FSEL_I};
         sdi_s <= {sdi_s[0], SDI_I};
      end
   end

   // Half-period divider, stopped while idle
   logic [6:0] pre_last;
   assign pre_last = (PRESCALE_I[7:1] == 7'h00) ? 7'h00 : PRESCALE_I[7:1] - 7'h01;
   // period is prescale times rate plus one
   assign tick = (pre_cnt == pre_last) && (rate_cnt == RATE_I);
   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I || state == ST_IDLE || SLAVE_I)
      begin
         pre_cnt <= 7'h00;
         rate_cnt <= 8'h00;
      end
      else if (pre_cnt == pre_last)
      begin
         pre_cnt <= 7'h00;
         rate_cnt <= (rate_cnt == RATE_I) ? 8'h00 : rate_cnt + 8'h01;
      end
      else
         pre_cnt <= pre_cnt + 7'h01;
   end

   // Frame events from the divider or from the external clock
   logic s_edge, lead_ev, trail_ev, cap_ev, m_start, s_start, s_pstart, start_any;
   logic active, frame_done;
   assign s_edge = sclk_s[1] ^ sclk_s[2];
   assign lead_ev = (state == ST_SHIFT) &&
                    (SLAVE_I ? s_edge && (sclk_s[1] != eff_pol) : tick && !half);
   assign trail_ev = (state == ST_SHIFT) &&
                     (SLAVE_I ? s_edge && (sclk_s[1] == eff_pol) : tick && half);
   assign cap_ev = eff_phase ? trail_ev : lead_ev;
   assign m_start = ENABLE_I && !SLAVE_I && (state == ST_IDLE) && (tx_cnt != '0);
   // slave starts when idle and the synchronised frame select falls
   assign s_start = ENABLE_I && SLAVE_I && (state == ST_IDLE) && !pulse &&
                    fsel_s[2] && !fsel_s[1];
   assign s_pstart = ENABLE_I && SLAVE_I && (state == ST_IDLE) && pulse &&
                     fsel_s[1] && sclk_s[1] && !sclk_s[2];
   assign start_any = m_start || s_start || s_pstart;
   assign active = ENABLE_I && !(SLAVE_I && !pulse && fsel_s[1]);
   assign frame_done = active && trail_ev && (bi == last);

   // Frame engine
   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
      begin
         state <= ST_IDLE;
         bi <= 5'h00;
         half <= 1'b0;
         sclk <= 1'b0;
         fsel <= 1'b1;
         sdo <= 1'b0;
         txw <= 16'h0000;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               sclk <= eff_pol;
               fsel <= !pulse;
               half <= s_pstart;
               bi <= 5'h00;
               if (start_any)
               begin
                  // head word loaded, stale or zero if empty
                  txw <= tx_head;
                  sdo <= tx_bit(FORMAT_I, sz, tx_head, `SSPC_BIT_ZERO);
                  // frame select drops ahead of first edge
                  fsel <= 1'b0;
                  state <= m_start ? ST_START : ST_SHIFT;
               end
            end
            ST_START:
               if (!ENABLE_I)
                  state <= ST_IDLE;
               else if (tick)
                  state <= ST_SHIFT;
            ST_SHIFT:
               if (!active)
                  state <= ST_IDLE;
               else if (lead_ev)
               begin
                  half <= 1'b1;
                  sclk <= !eff_pol;
                  // pulse high for bit zero only
                  if (pulse)
                     fsel <= (bi == `SSPC_BIT_ZERO);
                  // change on leading edge when phase set
                  if (eff_phase)
                     sdo <= tx_bit(FORMAT_I, sz, txw, bi);
               end
               else if (trail_ev)
               begin
                  half <= 1'b0;
                  sclk <= eff_pol;
                  if (!eff_phase && bi != last)
                     sdo <= tx_bit(FORMAT_I, sz, txw, bi + 5'h01);
                  if (bi == last)
                     state <= (!SLAVE_I && !pulse) ? ST_STOP : ST_IDLE;
                  else
                     bi <= bi + 5'h01;
               end
            ST_STOP:
               // select held one period past the last bit
               if (tick)
               begin
                  half <= !half;
                  if (half)
                     state <= ST_IDLE;
               end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Receive shifter; bits before the reply window are ignored
   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I || start_any)
         rxsh <= 16'h0000;
      // control message phase does not capture
      else if (active && cap_ev && bi >= rx_first)
         rxsh <= {rxsh[14:0], sdi_s[1]};
   end

   // Registered word pushed the cycle after the frame ends
   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
         push_d <= 1'b0;
      else
         push_d <= frame_done;
   end

   // Transmit FIFO; slots cleared at reset so unwritten slots send zero
   logic tx_push, tx_pop;
   assign tx_push = TX_WRITE_I && (tx_cnt != FULL);
   assign tx_pop = start_any && (tx_cnt != '0);
   // push on write, pop on frame start
   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
      begin
         tx_wr <= '0;
         tx_rd <= '0;
         tx_cnt <= '0;
         for (int i = 0; i < DEPTH; i++)
            tx_mem[i] <= 16'h0000;
      end
      else
      begin
         if (tx_push)
         begin
            tx_mem[tx_wr] <= TX_DATA_I;
            tx_wr <= tx_wr + AW'(1);
         end
         // empty start leaves pointer on the stale slot
         if (tx_pop)
            tx_rd <= tx_rd + AW'(1);
         tx_cnt <= tx_cnt + CW'(tx_push) - CW'(tx_pop);
      end
   end

   // Receive FIFO; a push into a full store is dropped
   logic rx_push, rx_pop;
   assign rx_push = push_d && (rx_cnt != FULL);
   assign rx_pop = RX_READ_I && (rx_cnt != '0);
   // push on frame end, pop on read
   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
      begin
         rx_wr <= '0;
         rx_rd <= '0;
         rx_cnt <= '0;
         for (int i = 0; i < DEPTH; i++)
            rx_mem[i] <= 16'h0000;
      end
      else
      begin
         if (rx_push)
         begin
            rx_mem[rx_wr] <= rxsh;
            rx_wr <= rx_wr + AW'(1);
         end
         if (rx_pop)
            rx_rd <= rx_rd + AW'(1);
         rx_cnt <= rx_cnt + CW'(rx_push) - CW'(rx_pop);
      end
   end

   // Timeout counts idle cycles with unread data
   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I || state != ST_IDLE || rx_cnt == '0 || rx_pop)
      begin
         to_cnt <= '0;
         rx_timeout <= 1'b0;
      end
      // flag after the full idle period
      else if (to_cnt == `SSPC_TO_W'(RX_TIMEOUT_CYCLES - 1))
         rx_timeout <= 1'b1;
      else
         to_cnt <= to_cnt + `SSPC_TO_W'(1);
   end

   // Overrun is sticky; a new overrun beats a clear
   always_ff @(posedge CLOCK_I)
   begin
      if (RST_I)
         ovr <= 1'b0;
      // full store drops the word and flags
      else if (push_d && rx_cnt == FULL)
         ovr <= 1'b1;
      else if (OVERRUN_CLEAR_I)
         ovr <= 1'b0;
   end

   // Status and interrupt outputs
   // four conditions
   assign RAW_IRQ_O[`SSPC_IRQ_TX] = (tx_cnt <= HALF);
   assign RAW_IRQ_O[`SSPC_IRQ_RX] = (rx_cnt >= HALF);
   assign RAW_IRQ_O[`SSPC_IRQ_TO] = rx_timeout;
   assign RAW_IRQ_O[`SSPC_IRQ_OVR] = ovr;
   assign MASKED_IRQ_O = RAW_IRQ_O & IRQ_MASK_I;
   assign IRQ_O = |MASKED_IRQ_O;
   assign BUSY_O = (state != ST_IDLE);
   assign TX_READY_O = (tx_cnt != FULL);
   assign RX_VALID_O = (rx_cnt != '0);
   assign RX_DATA_O = rx_mem[rx_rd];

   // Pin drivers; slave never drives clock or select
   assign SCLK_O = sclk;
   assign SCLK_OE_O = ENABLE_I && !SLAVE_I;
   assign FSEL_O = fsel;
   assign FSEL_OE_O = ENABLE_I && !SLAVE_I;
   assign SDO_O = sdo;
   assign SDO_OE_O = ENABLE_I && (BUSY_O || (!SLAVE_I && !pulse));

   // Checks on the engine, FIFOs and status
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (RST_I);

   sequence s_frame_end;
      frame_done ##1 push_d;
   endsequence

   a_idle_clock: assert property (!SLAVE_I && state == ST_IDLE && $past(state) == ST_IDLE &&
      $stable(eff_pol) |-> SCLK_O == eff_pol) else $error("idle clock level wrong");
   a_tx_push_count: assert property (tx_push && !tx_pop |=> tx_cnt == $past(tx_cnt) + CW'(1))
      else $error("tx push not counted");
   a_rx_pop_count: assert property (rx_pop && !rx_push |=> rx_cnt == $past(rx_cnt) - CW'(1))
      else $error("rx pop not counted");
   a_stale_word: assert property (start_any |=> txw == $past(tx_head))
      else $error("start did not load head slot");
   a_mask_block: assert property (IRQ_MASK_I == 4'h0 |-> !IRQ_O)
      else $error("masked request leaked");
   a_overrun_set: assert property (s_frame_end ##0 rx_cnt == FULL |=>
      ovr && rx_cnt == FULL - CW'($past(rx_pop)))
      else $error("overrun not flagged");
   a_timeout_wait: assert property ($rose(rx_timeout) |->
      $past(to_cnt) == `SSPC_TO_W'(RX_TIMEOUT_CYCLES - 1) && rx_cnt != '0)
      else $error("timeout early");
   a_select_low: assert property (!SLAVE_I && !pulse && state == ST_SHIFT |-> !FSEL_O)
      else $error("select high during frame");
   a_pulse_start: assert property (!SLAVE_I && pulse && $rose(fsel) |->
      state == ST_SHIFT && half && bi == `SSPC_BIT_ZERO && SCLK_O)
      else $error("frame pulse misplaced");
   a_cmd_quiet: assert property (cmd && cap_ev && bi < rx_first && !start_any |=>
      $stable(rxsh)) else $error("input taken during control message");
endmodule

// ==== sspc_cfg.svh ====
// Fixed constants of the synchronous serial port core
`ifndef SSPC_CFG_SVH
`define SSPC_CFG_SVH
`define SSPC_WORD_W 16
`define SSPC_MIN_SIZE 4'h3
`define SSPC_PULSE_LEAD 5'h01
`define SSPC_CMD_BITS 5'h08
`define SSPC_CMD_GAP 5'h01
`define SSPC_BIT_ZERO 5'h00
`define SSPC_IRQ_TX 0
`define SSPC_IRQ_RX 1
`define SSPC_IRQ_TO 2
`define SSPC_IRQ_OVR 3
`define SSPC_TO_W 16
`endif

// ==== sspc_pkg.sv ====
// Types shared by the synchronous serial port core
package sspc_pkg;
   typedef enum logic [1:0] {SSPC_FMT_PULSE, SSPC_FMT_SPI, SSPC_FMT_CMD} sspc_fmt_e;
   typedef enum logic [1:0] {ST_IDLE, ST_START, ST_SHIFT, ST_STOP} sspc_state_e;
endpackage

// ==== sspc_peer.sv ====
// Behavioural off-chip serial peripheral for the port bench
`timescale 1ns/100ps
module sspc_peer (
   // Clock and role
   input wire logic clk_i,
   input wire logic master_i,
   // Frame settings
   input wire logic cpol_i,
   input wire logic cpha_i,
   input wire logic pulsed_i,
   input wire logic [4:0] n_i,
   input wire logic [15:0] reply_i,
   // Serial pins
   input wire logic sclk_i,
   input wire logic fsel_i,
   input wire logic sdo_i,
   output logic sdi_o = 1'b0,
   output logic sclk_o = 1'b0,
   output logic fsel_o = 1'b1,
   output logic [15:0] got_o = 16'h0000
);
   int idx = 0;
   logic armed = 1'b0;
   always @(negedge fsel_i) if (!master_i && !pulsed_i)
   begin
      idx = n_i;
      got_o = 16'h0000;
      if (!cpha_i)
      begin
         idx = n_i - 1;
         sdi_o = reply_i[idx];
      end
   end
   // Released line shows the inverse, never a stale bit
   always @(posedge fsel_i) if (!master_i)
      sdi_o = ~sdi_o;
   always @(sclk_i) if (!master_i)
   begin
      if (pulsed_i && !sclk_i && fsel_i)
      begin
         idx = n_i;
         armed = 1'b1;
         got_o = 16'h0000;
      end
      else if (pulsed_i ? armed : !fsel_i)
      begin
         if (sclk_i ^ cpol_i ^ cpha_i)
         begin
            got_o = {got_o[14:0], sdo_i};
            if (pulsed_i && idx == 0)
               armed = 1'b0;
         end
         else if (idx > 0)
         begin
            idx--;
            sdi_o = reply_i[idx];
         end
      end
   end
   // master role, serial clock one sixteenth of system
   task automatic master_frame(input logic [15:0] w, output logic [15:0] r);
      r = 16'h0000;
      @(posedge clk_i);
      fsel_o <= 1'b0;
      sdi_o <= w[n_i - 1];
      for (int i = n_i - 1; i >= 0; i--)
      begin
         repeat (8) @(posedge clk_i);
         r = {r[14:0], sdo_i};
         sclk_o <= 1'b1;
         repeat (8) @(posedge clk_i);
         sclk_o <= 1'b0;
         if (i > 0)
            sdi_o <= w[i - 1];
      end
      repeat (8) @(posedge clk_i);
      fsel_o <= 1'b1;
   endtask
endmodule

// ==== tb_sync_serial_port_core.sv ====
// Self-checking bench of the synchronous serial port core
`timescale 1ns/100ps
module tb_sync_serial_port_core;
   import sspc_pkg::*;
   logic clk = 1'b0, rst = 1'b1, enable = 1'b0, slave = 1'b0, pol = 1'b0, pha = 1'b0;
   sspc_fmt_e fmt = SSPC_FMT_SPI;
   logic [3:0] size = 4'h7, mask = 4'h0, raw, masked;
   logic [7:0] presc = 8'h04, rate = 8'h01;
   logic ovr_clr = 1'b0, tx_wr = 1'b0, rx_rd = 1'b0, tx_ready, rx_valid, irq, busy;
   logic [15:0] tx_data = 16'h0000, rx_data, p_got, p_reply = 16'h0000, r;
   logic sclk_o, sclk_oe, fsel_o, fsel_oe, sdo, sdo_oe, p_sdi, p_sclk, p_fsel;
   logic p_master = 1'b0, p_cpol = 1'b0, p_cpha = 1'b0, p_pulsed = 1'b0;
   logic [4:0] p_n = 5'h08;
   wire logic sclk_w = sclk_oe ? sclk_o : p_sclk;
   wire logic fsel_w = fsel_oe ? fsel_o : p_fsel;
   int fails = 0, checks_done = 0, rises = 0, per = 0, fs_hi = 0;
   time t_last = 0;
   always #5 clk = ~clk;
   sspc_core #(.DEPTH(8), .RX_TIMEOUT_CYCLES(16)) i_dut (.CLOCK_I(clk), .RST_I(rst),
      .ENABLE_I(enable), .SLAVE_I(slave), .FORMAT_I(fmt), .SIZE_I(size), .POLARITY_I(pol),
      .PHASE_I(pha), .PRESCALE_I(presc), .RATE_I(rate), .IRQ_MASK_I(mask),
      .OVERRUN_CLEAR_I(ovr_clr), .TX_DATA_I(tx_data), .TX_WRITE_I(tx_wr),
      .TX_READY_O(tx_ready), .RX_READ_I(rx_rd), .RX_DATA_O(rx_data), .RX_VALID_O(rx_valid),
      .RAW_IRQ_O(raw), .MASKED_IRQ_O(masked), .IRQ_O(irq), .BUSY_O(busy), .SCLK_I(sclk_w),
      .SCLK_O(sclk_o), .SCLK_OE_O(sclk_oe), .FSEL_I(fsel_w), .FSEL_O(fsel_o),
      .FSEL_OE_O(fsel_oe), .SDI_I(p_sdi), .SDO_O(sdo), .SDO_OE_O(sdo_oe));
   sspc_peer i_peer (.clk_i(clk), .master_i(p_master), .cpol_i(p_cpol), .cpha_i(p_cpha),
      .pulsed_i(p_pulsed), .n_i(p_n), .reply_i(p_reply), .sclk_i(sclk_w), .fsel_i(fsel_w),
      .sdo_i(sdo), .sdi_o(p_sdi), .sclk_o(p_sclk), .fsel_o(p_fsel), .got_o(p_got));
   // Serial clock rises and the spacing of the last two
   always @(posedge sclk_w)
   begin
      per = int'($time - t_last);
      t_last = $time;
      rises++;
   end
   // Width of the pulsed frame marker in system cycles
   always @(negedge clk)
      if (fmt == SSPC_FMT_PULSE && busy === 1'b1 && fsel_o === 1'b1) fs_hi++;
   task automatic give_verdict;
      $display("Checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check_word(input logic [15:0] g, input logic [15:0] e);
      checks_done++;
      if (g !== e)
      begin
         fails++;
         $display("ERROR %0t word %h expected %h", $time, g, e);
      end
   endtask
   task automatic check_flags(input logic [3:0] g, input logic [3:0] e);
      checks_done++;
      if (g !== e)
      begin
         fails++;
         $display("ERROR %0t flags %b expected %b", $time, g, e);
      end
   endtask
   task automatic check_num(input int g, input int e);
      checks_done++;
      if (g != e)
      begin
         fails++;
         $display("ERROR %0t count %0d expected %0d", $time, g, e);
      end
   endtask
   task automatic push(input logic [15:0] w);
      @(posedge clk);
      tx_data <= w;
      tx_wr <= 1'b1;
      @(posedge clk);
      tx_wr <= 1'b0;
   endtask
   task automatic pop(input logic [15:0] e);
      @(negedge clk);
      check_flags({3'h0, rx_valid}, 4'h1);
      check_word(rx_data, e);
      @(posedge clk);
      rx_rd <= 1'b1;
      @(posedge clk);
      rx_rd <= 1'b0;
   endtask
   // Bounded wait for the engine to fall idle
   task automatic wait_idle;
      int k;
      repeat (3) @(posedge clk);
      for (k = 0; k < 5000; k++)
      begin
         @(negedge clk);
         if (busy === 1'b0)
            break;
      end
      if (k == 5000)
      begin
         fails++;
         give_verdict();
      end
   endtask
   // One master frame, then idle time to see the clock stay still
   task automatic frame(input logic [15:0] w, input logic [15:0] rep, input logic [4:0] n);
      p_reply = rep;
      p_n = n;
      rises = 0;
      fs_hi = 0;
      push(w);
      wait_idle();
      repeat (12) @(posedge clk);
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      enable <= 1'b1;
      @(posedge clk);
      mask <= 4'h1;
      @(negedge clk);
      check_flags(raw, 4'h1);
      check_flags({tx_ready, rx_valid, irq, masked[0]}, 4'hb);
      check_flags({1'b0, sclk_oe, fsel_oe, sdo_oe}, 4'h7);
      @(posedge clk);
      mask <= 4'he;
      @(negedge clk);
      check_flags({irq, masked[2:0]}, 4'h0);
      for (int m = 0; m < 5; m++)
      begin
         @(posedge clk);
         pol <= m[1];
         pha <= m[0];
         size <= 4'hf;
         presc <= (m == 4) ? 8'h06 : 8'h04;
         rate <= (m == 4) ? 8'h02 : 8'h01;
         p_cpol = m[1];
         p_cpha = m[0];
         repeat (3) @(posedge clk);
         @(negedge clk);
         check_flags({3'h0, sclk_o}, {3'h0, m[1]});
         frame(16'hc3a5 ^ m[15:0], 16'h5e71 + m[15:0], 5'h10);
         check_word(p_got, 16'hc3a5 ^ m[15:0]);
         check_num(rises, 16);
         check_num(per, (m == 4) ? 180 : 80);
         pop(16'h5e71 + m[15:0]);
      end
      @(posedge clk);
      fmt <= SSPC_FMT_PULSE;
      size <= 4'h7;
      p_pulsed = 1'b1;
      p_cpha = 1'b1;
      frame(16'h0096, 16'h005a, 5'h08);
      check_word(p_got, 16'h0096);
      check_num(fs_hi, 18);
      check_num(rises, 9);
      pop(16'h005a);
      @(posedge clk);
      fmt <= SSPC_FMT_CMD;
      size <= 4'h3;
      p_pulsed = 1'b0;
      p_cpha = 1'b0;
      frame(16'h00c5, 16'h1fea, 5'h0d);
      check_word({8'h00, p_got[12:5]}, 16'h00c5);
      check_num(rises, 13);
      pop(16'h000a);
      @(posedge clk);
      fmt <= SSPC_FMT_SPI;
      size <= 4'h7;
      slave <= 1'b1;
      p_master = 1'b1;
      p_n = 5'h08;
      repeat (4) @(posedge clk);
      @(negedge clk);
      check_flags({1'b0, sclk_oe, fsel_oe, sdo_oe}, 4'h0);
      i_peer.master_frame(16'h0077, r);
      check_word(r, 16'h0000);
      repeat (8) @(posedge clk);
      pop(16'h0077);
      for (int i = 0; i < 9; i++) push(16'h0030 + i[15:0]);
      @(negedge clk);
      check_flags({3'h0, tx_ready}, 4'h0);
      for (int i = 0; i < 9; i++)
      begin
         i_peer.master_frame(16'h0040 + i[15:0], r);
         check_word(r, (i < 8) ? 16'h0030 + i[15:0] : 16'h0030);
         repeat (8) @(posedge clk);
      end
      repeat (30) @(posedge clk);
      mask <= 4'h5;
      @(negedge clk);
      check_flags(raw, 4'hf);
      check_flags({irq, masked[2:0]}, 4'hd);
      for (int i = 0; i < 8; i++) pop(16'h0040 + i[15:0]);
      repeat (2) @(posedge clk);
      @(negedge clk);
      check_flags(raw, 4'h9);
      @(posedge clk);
      ovr_clr <= 1'b1;
      @(posedge clk);
      ovr_clr <= 1'b0;
      @(negedge clk);
      check_flags(raw, 4'h1);
      give_verdict();
   end
endmodule
